// *** dv/sbk_ctl_model.sv ***
// Purpose: Controller model. Assumes: Bench picks commands. Notes: Deselect inverts lines.
`timescale 1ns/1ps
`default_nettype none
module sbk_ctl_model (
  // Request and strobes.
  input  wire logic [3:0]  cmd,
  input  wire logic [1:0]  sel,
  input  wire logic [9:0]  lo,
  output wire logic [3:0]  strb,
  output wire logic [11:0] addr
);
  // A deselected bus shows a changing pattern, so a stale command cannot pass.
  assign strb = cmd[3] ? {1'b1, ~cmd[2:0]} : cmd;
  assign addr = cmd[3] ? ~{sel, lo} : {sel, lo};
endmodule // sbk_ctl_model
`default_nettype wire

// *** dv/sbk_top_asserts.sv ***
// Purpose: Bank 0 checks. Assumes: One clock. Notes: Bank 1 is left to the bench.
`timescale 1ns/1ps
`default_nettype none
module sbk_top_asserts (
  // Watched ports.
  input wire logic        SYS_CLK,
  input wire logic        SRST,
  input wire logic        CS_N,
  input wire logic        RAS_N,
  input wire logic        CAS_N,
  input wire logic        WE_N,
  input wire logic [11:0] ADDR,
  input wire logic [2:0]  BANK0_STATE,
  input wire logic        ILLEGAL0
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  wire [2:0] s = BANK0_STATE;
  // Refresh, config and close-all reach both banks.
  wire h = !CS_N & (!ADDR[11] | !RAS_N & !CAS_N | !RAS_N & !WE_N & ADDR[10]);
  wire n = CS_N | RAS_N & CAS_N & WE_N;
  wire row_open = h & !RAS_N & CAS_N & WE_N;
  sequence s_open; s == 3'h2 [*4] ##1 s == 3'h1; endsequence
  sequence s_wac; s == 3'h5 [*4] ##1 s == 3'h3 [*7] ##1 s == 3'h0; endsequence
  sequence s_rec; s == 3'h4 ##1 s == 3'h6 ##0 (n | !RAS_N) [*3]; endsequence
  chk_open_time: assert property (s == 3'h0 && row_open |=> s_open) else $error("open");
  chk_open_bad: assert property (s == 3'h2 && h && !(RAS_N & CAS_N) |=> ILLEGAL0)
    else $error("open guard");
  chk_wac_close: assert property (s == 3'h1 && h && RAS_N && !CAS_N && !WE_N && ADDR[10]
    |=> s_wac) else $error("autoclose");
  chk_wac_bad: assert property (s == 3'h5 && h && !n |=> ILLEGAL0) else $error("wac");
  chk_close_bad: assert property (s == 3'h3 && h && (!CAS_N | row_open) |=> ILLEGAL0)
    else $error("close guard");
  chk_close_quiet: assert property (s == 3'h3 && (n | CAS_N & !WE_N) |=> !ILLEGAL0)
    else $error("close quiet");
  chk_rec_time: assert property (s_rec |-> $past(s, 2) == 3'h6 && s == 3'h6 ##1 s == 3'h1)
    else $error("recovery");
  chk_rec_bad: assert property (s == 3'h6 && h && !RAS_N |=> ILLEGAL0) else $error("rec");
  chk_rec_accept: assert property (s == 3'h6 && h && RAS_N && !CAS_N
    |=> !ILLEGAL0 && (s == 3'h7 || s == 3'h4 || s == 3'h5)) else $error("rec accept");
endmodule // sbk_top_asserts
bind sbk_top sbk_top_asserts i_chk (.SYS_CLK(SYS_CLK), .SRST(SRST), .CS_N(CS_N), .RAS_N(RAS_N),
  .CAS_N(CAS_N), .WE_N(WE_N), .ADDR(ADDR), .BANK0_STATE(BANK0_STATE), .ILLEGAL0(ILLEGAL0));
`default_nettype wire

// *** dv/tb_sbk_top.sv ***
// Purpose: Bench for sbk_top. Assumes: 250 MHz clock. Notes: Rows hold cmd, check, bank, note.
`timescale 1ns/1ps
`default_nettype none
module tb_sbk_top;
  logic            clk = 1'b0, srst = 1'b1;
  logic [3:0]      cmd = 4'h8;
  logic [1:0]      sel = 2'h0;
  logic [9:0]      lo = 10'h0;
  logic [8:0]      p = 9'h0, x;
  logic [8:0]      q[$];
  wire logic [3:0]  strb;
  wire logic [11:0] addr;
  wire logic [2:0]  st0, st1;
  wire logic        ill0, ill1;
  integer          seed = 88, error_cnt = 0, tests_run = 0;
  logic [15:0]     t[51] = '{16'h3802, 16'h5842, 16'h6802, 16'h7802, 16'h7801,
    16'h4804, 16'h8000, 16'h8000, 16'h8000, 16'h7806, 16'h3846, 16'h7806, 16'h7801,
    16'h4804, 16'h8000, 16'h8000, 16'h8000, 16'h7806, 16'h5807, 16'h8000, 16'h8000,
    16'h8000, 16'h7801, 16'h4905, 16'h6845, 16'h8000, 16'h8000, 16'h7803, 16'h2803,
    16'h5843, 16'h3a13, 16'h8000, 16'h8000, 16'h8000, 16'h7808, 16'h2a18, 16'h3a98,
    16'h8000, 16'h8000, 16'h8800, 16'h3802, 16'h1842, 16'h8000, 16'h8000, 16'h7801,
    16'h2b03, 16'h0843, 16'h8000, 16'h8000, 16'h8800, 16'h8000};
  initial forever #2 clk = ~clk;
  sbk_ctl_model i_ctl (.cmd(cmd), .sel(sel), .lo(lo), .strb(strb), .addr(addr));
  sbk_top i_dut (.SYS_CLK(clk), .SRST(srst), .CS_N(strb[3]), .RAS_N(strb[2]), .CAS_N(strb[1]),
    .WE_N(strb[0]), .ADDR(addr), .BANK0_STATE(st0), .BANK1_STATE(st1), .ILLEGAL0(ill0),
    .ILLEGAL1(ill1));
  task chk(input logic [7:0] s, input logic [7:0] e);
    tests_run = tests_run + 1;
    if (s !== e)
    begin
      error_cnt = error_cnt + 1;
      $display("[ERR] %0t %h %h", $time, s, e);
    end
  endtask
  task final_report;
    if (error_cnt == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // A note is queued one edge late, so it meets the outputs of the edge that took its command.
  always @(negedge clk)
    while (q.size() > 0)
    begin
      x = q.pop_front();
      if (x[8])
        chk({ill1, ill0, st1, st0}, x[7:0]);
    end
  initial
  begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    foreach (t[i])
    begin
      @(posedge clk);
      cmd <= t[i][15:12];
      sel <= t[i][9:8];
      lo <= 10'($random(seed));
      q.push_back(p);
      p = {t[i][11], t[i][7:0]};
    end
    @(posedge clk);
    final_report();
  end
endmodule // tb_sbk_top
`default_nettype wire

// *** logic/sbk_bank_fsm.v ***
// Purpose: State machine of one bank for the post-write, open and close phases.
// Assumes: Commands arrive already decoded and qualified for this bank.
// Notes: Illegal commands in the opening, autoclose write, closing and recovery states are flagged and leave the state unchanged.
`timescale 1ns/1ps
`default_nettype none
`include "sbk_map.vh"
module sbk_bank_fsm #(
  parameter CW = 4,
  parameter [CW-1:0] T_CLOSE = `SBK_CYC(`SBK_CLOSE_TO_IDLE_NS),
  parameter [CW-1:0] T_OPEN = `SBK_CYC(`SBK_OPEN_TO_COLUMN_NS),
  parameter [CW-1:0] T_REC = `SBK_CYC(`SBK_LAST_DATA_TO_CLOSE_NS),
  parameter [CW-1:0] BURST = `SBK_BURST_LEN
) (
  // Clock and reset.
  input  wire       clk,
  input  wire       srst,
  // Decoded command.
  input  wire       sel,
  input  wire [2:0] cmd,
  input  wire       autoclose,
  // Bank state and error pulse.
  output reg  [2:0] state_reg,
  output reg        illegal_reg
);
  reg [2:0]    state_next;
  reg [CW-1:0] cnt_reg;
  reg [CW-1:0] cnt_next;
  reg          bad;
  wire         idle_cmd = (cmd == `SBK_CMD_DESELECT) || (cmd == `SBK_CMD_NO_OPERATION);
  wire         soft_cmd = idle_cmd || (cmd == `SBK_CMD_BURST_TERM);
  wire         done = (cnt_reg <= 4'h1);
  wire [CW-1:0] dec = cnt_reg - 4'h1;

  always @*
  begin
    state_next = state_reg;
    cnt_next = done ? cnt_reg : dec;
    bad = 1'b0;
    case (state_reg)
      `SBK_ST_IDLE:
      begin
        if (sel && cmd == `SBK_CMD_ROW_OPEN)
        begin
          state_next = `SBK_ST_OPENING;
          cnt_next = T_OPEN;
        end
      end
      `SBK_ST_OPENING:
      begin
        if (sel && !soft_cmd)
          bad = 1'b1;
        if (done)
          state_next = `SBK_ST_ACTIVE;
      end
      `SBK_ST_ACTIVE:
      begin
        if (sel && cmd == `SBK_CMD_STORE)
        begin
          state_next = autoclose ? `SBK_ST_WRITE_AC : `SBK_ST_WRITE;
          cnt_next = BURST;
        end
        else if (sel && cmd == `SBK_CMD_READ)
        begin
          state_next = `SBK_ST_READ;
          cnt_next = BURST;
        end
        else if (sel && cmd == `SBK_CMD_CLOSE)
        begin
          state_next = `SBK_ST_CLOSING;
          cnt_next = T_CLOSE;
        end
      end
      `SBK_ST_WRITE, `SBK_ST_READ:
      begin
        if (done)
        begin
          state_next = (state_reg == `SBK_ST_WRITE) ? `SBK_ST_RECOVERY : `SBK_ST_ACTIVE;
          cnt_next = T_REC;
        end
      end
      `SBK_ST_WRITE_AC:
      begin
        if (sel && !idle_cmd)
          bad = 1'b1;
        if (done)
        begin
          // Recovery and close are folded into one wait; the close follows unasked.
          state_next = `SBK_ST_CLOSING;
          cnt_next = T_REC + T_CLOSE;
        end
      end
      `SBK_ST_CLOSING:
      begin
        if (sel && !soft_cmd && cmd != `SBK_CMD_CLOSE)
          bad = 1'b1;
        if (done)
          state_next = `SBK_ST_IDLE;
      end
      `SBK_ST_RECOVERY:
      begin
        if (sel && cmd == `SBK_CMD_READ)
        begin
          state_next = `SBK_ST_READ;
          cnt_next = BURST;
        end
        else if (sel && cmd == `SBK_CMD_STORE)
        begin
          state_next = autoclose ? `SBK_ST_WRITE_AC : `SBK_ST_WRITE;
          cnt_next = BURST;
        end
        else if (sel && !soft_cmd)
          bad = 1'b1;
        else if (done)
          state_next = `SBK_ST_ACTIVE;
      end
      default:
        state_next = `SBK_ST_IDLE;
    endcase
    if (bad)
      state_next = state_reg;
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      state_reg <= `SBK_ST_IDLE;
      cnt_reg <= {CW{1'b0}};
      illegal_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      illegal_reg <= bad;
    end
  end
endmodule // sbk_bank_fsm
`default_nettype wire

// *** logic/sbk_map.vh ***
// Purpose: Constants for the two-bank command state block.
// Assumes: Commands decoded from chip select, row, column and write strobes.
// Notes: Timing counts are whole cycles of the 250 MHz clock.
`ifndef SBK_MAP_VH
`define SBK_MAP_VH
`define SBK_CLK_PERIOD_NS 4
`define SBK_CLOSE_TO_IDLE_NS 15
`define SBK_OPEN_TO_COLUMN_NS 15
`define SBK_LAST_DATA_TO_CLOSE_NS 10
`define SBK_CYC(ns) (((ns) + `SBK_CLK_PERIOD_NS - 1) / `SBK_CLK_PERIOD_NS)
`define SBK_BURST_LEN 4'h4
`define SBK_BANK_SEL_BIT 4'hb
`define SBK_AUTOCLOSE_BIT 4'ha
`define SBK_CMD_DESELECT 3'h0
`define SBK_CMD_NO_OPERATION 3'h1
`define SBK_CMD_BURST_TERM 3'h2
`define SBK_CMD_READ 3'h3
`define SBK_CMD_STORE 3'h4
`define SBK_CMD_ROW_OPEN 3'h5
`define SBK_CMD_CLOSE 3'h6
`define SBK_CMD_OTHER 3'h7
`define SBK_ST_IDLE 3'h0
`define SBK_ST_ACTIVE 3'h1
`define SBK_ST_OPENING 3'h2
`define SBK_ST_CLOSING 3'h3
`define SBK_ST_WRITE 3'h4
`define SBK_ST_WRITE_AC 3'h5
`define SBK_ST_RECOVERY 3'h6
`define SBK_ST_READ 3'h7
`endif

// *** logic/sbk_top.v ***
// Purpose: Command decode and two bank state machines of a two-bank DRAM.
// Assumes: Strobes are active low and synchronous to SYS_CLK.
// Notes: Bursts and data are not modelled; a fixed burst length stands in.
`timescale 1ns/1ps
`default_nettype none
`include "sbk_map.vh"
module sbk_top #(
  parameter BANK_SEL_BIT = `SBK_BANK_SEL_BIT,
  parameter AUTOCLOSE_BIT = `SBK_AUTOCLOSE_BIT
) (
  // Clock and reset.
  input  wire        SYS_CLK,
  input  wire        SRST,
  // Command strobes.
  input  wire        CS_N,
  input  wire        RAS_N,
  input  wire        CAS_N,
  input  wire        WE_N,
  input  wire [11:0] ADDR,
  // Bank states and error pulses.
  output wire [2:0]  BANK0_STATE,
  output wire [2:0]  BANK1_STATE,
  output wire        ILLEGAL0,
  output wire        ILLEGAL1
);
  reg  [2:0] cmd;
  wire       bank_select_bit = ADDR[BANK_SEL_BIT];
  wire       autoclose = ADDR[AUTOCLOSE_BIT];

  // Inputs are used only at the rising edge, inside the bank flops.
  always @*
  begin
    if (CS_N)
      cmd = `SBK_CMD_DESELECT;
    else
      case ({RAS_N, CAS_N, WE_N})
        3'h7: cmd = `SBK_CMD_NO_OPERATION;
        3'h6: cmd = `SBK_CMD_BURST_TERM;
        3'h5: cmd = `SBK_CMD_READ;
        3'h4: cmd = `SBK_CMD_STORE;
        3'h3: cmd = `SBK_CMD_ROW_OPEN;
        3'h2: cmd = `SBK_CMD_CLOSE;
        default: cmd = `SBK_CMD_OTHER;
      endcase
  end

  // A bank-wide close-all targets both; refresh and config hit both too.
  wire all_banks = (cmd == `SBK_CMD_OTHER) || (cmd == `SBK_CMD_CLOSE && autoclose);

  sbk_bank_fsm u_bank0 (
    .clk         (SYS_CLK),
    .srst        (SRST),
    .sel         (!bank_select_bit || all_banks),
    .cmd         (cmd),
    .autoclose   (autoclose),
    .state_reg   (BANK0_STATE),
    .illegal_reg (ILLEGAL0)
  );

  sbk_bank_fsm u_bank1 (
    .clk         (SYS_CLK),
    .srst        (SRST),
    .sel         (bank_select_bit || all_banks),
    .cmd         (cmd),
    .autoclose   (autoclose),
    .state_reg   (BANK1_STATE),
    .illegal_reg (ILLEGAL1)
  );
endmodule // sbk_top
`default_nettype wire
